/* rtl/flash_prog.sv */
// in-system flash programming sequencer with its four special function registers
// Functional notes
// (R1) hardware sequences byte program, chip erase, page erase, protect from registers
// (R2) service area sized in 512-byte steps by lock value 0..8
// (R3) lock zero means no service area, whole region is program memory
// (R4) service area ends at region top and grows downward per lock step
// (R5) flash erase keeps the locked service area intact
// (R6) service area readable unless protected; after protect nothing is readable
// (R7) area locks automatically; only external programmer may erase it
// (R8) blank first location at reset starts at service area address
// (R9) core jump may transfer control to the service area start
// (R10) reset with both port-2 straps low enters service program if enabled
// (R11) reset with port-4 strap in entry state enters service program if enabled
// (R12) straps sampled only in reset window, entry needs no software
// (R13) firmware restarts normal code by reset, watchdog or jump to zero
// (R14) target address is high register over low register
// (R15) program or page erase inside service area has no flash effect
// (R16) eight-bit data register holds the byte to program
// (R17) all registers reset zero; control bit layout start, pgse, pgs, op
// (R18) op codes 00 program, 01 protect, 10 page, 11 chip; needs start
// (R19) page 512 bytes, or 256/128 when selection enabled; 11 reserved
// (R20) operation starts at control write; page erase clears the whole page
// (R21) chip erase spares service area; protected reads return zero
// (R22) fetch stalls while busy, then start bit clears
`timescale 1ns/100ps
`include "flash_prog_defines.svh"
module flash_prog
	import flash_prog_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	input wire logic [3:0] LOCK_N,
	input wire logic STRAP_P2_EN,
	input wire logic STRAP_P4_EN,
	input wire logic ENTRY_STRAP_A,
	input wire logic ENTRY_STRAP_B,
	input wire logic ENTRY_STRAP_C,
	input wire logic [7:0] FLASH_BYTE0,
	input wire logic FLASH_PROTECTED,
	input wire logic FLASH_READY,
	input wire logic [7:0] FLASH_RDATA_RAW,
	output logic [7:0] FLASH_RDATA,
	output logic FLASH_REQ,
	output logic [1:0] FLASH_OP,
	output logic [15:0] FLASH_ADDR,
	output logic [15:0] FLASH_LAST,
	output logic [7:0] FLASH_WDATA,
	output logic [15:0] FLASH_KEEP_FROM,
	output logic FETCH_STALL,
	output logic [15:0] RESET_VECTOR,
	output logic SERVICE_MODE,
	output logic [15:0] SERVICE_START
);
	logic [7:0] addr_high_r, addr_high_nxt;
	logic [7:0] addr_low_r, addr_low_nxt;
	logic [7:0] wbyte_r, wbyte_nxt;
	logic [7:0] ctl_r, ctl_nxt;
	seq_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic req_r, req_nxt;
	logic stall_r, stall_nxt;
	logic [3:0] win_r, win_nxt;
	logic service_r, service_nxt;
	logic [15:0] vector_r, vector_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [7:0] frd_r;
	logic sa_q, sb_q, sc_q;
	logic [15:0] target;
	logic [15:0] area_start, page_base, page_last;
	logic in_area, size_ok;
	logic ctl_write;

	strap_sync u_sync_a (.clk(CORE_CLK), .d(ENTRY_STRAP_A), .q(sa_q));
	strap_sync u_sync_b (.clk(CORE_CLK), .d(ENTRY_STRAP_B), .q(sb_q));
	strap_sync u_sync_c (.clk(CORE_CLK), .d(ENTRY_STRAP_C), .q(sc_q));

	assign target = {addr_high_r, addr_low_r}; // [R14]
	assign ctl_write = SFR_WR && SFR_ADDR == `SFR_OP_CONTROL;

	service_area_map u_map (
		.clk(CORE_CLK),
		.lock_n(LOCK_N),
		.target(target),
		.pgse(ctl_r[`CTL_PGSE_BIT]),
		.pgs(ctl_r[`CTL_PGS_HI:`CTL_PGS_LO]),
		.area_start(area_start),
		.in_area(in_area),
		.page_base(page_base),
		.page_last(page_last),
		.size_ok(size_ok)
	);

	// register file and read mux
	always_comb begin
		addr_high_nxt = addr_high_r;
		addr_low_nxt = addr_low_r;
		wbyte_nxt = wbyte_r;
		ctl_nxt = ctl_r;
		rdata_nxt = rdata_r;
		if (SFR_WR && state_r == ST_IDLE) begin
			unique case (SFR_ADDR)
				`SFR_ADDR_HIGH: addr_high_nxt = SFR_WDATA;
				`SFR_ADDR_LOW: addr_low_nxt = SFR_WDATA;
				`SFR_WRITE_BYTE: wbyte_nxt = SFR_WDATA; // [R16]
				`SFR_OP_CONTROL: ctl_nxt = SFR_WDATA & `CTL_WRITABLE_MASK; // [R17]
				default: ;
			endcase
		end
		if (state_r == ST_DONE) begin
			ctl_nxt[`CTL_START_BIT] = 1'b0; // [R22]
		end
		if (SFR_RD) begin
			unique case (SFR_ADDR)
				`SFR_ADDR_HIGH: rdata_nxt = addr_high_r;
				`SFR_ADDR_LOW: rdata_nxt = addr_low_r;
				`SFR_WRITE_BYTE: rdata_nxt = wbyte_r;
				`SFR_OP_CONTROL: rdata_nxt = ctl_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// operation sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		req_nxt = 1'b0;
		stall_nxt = stall_r;
		unique case (state_r)
			ST_IDLE: begin
				// start on control write with start set [R18] [R20]
				if (ctl_write && SFR_WDATA[`CTL_START_BIT]) begin
					state_nxt = ST_CHECK;
					stall_nxt = 1'b1; // [R22]
				end
			end
			ST_CHECK: begin
				state_nxt = ST_RUN;
				cnt_nxt = 4'(`OP_CYCLES);
				// service area writes and reserved page size are dropped [R15] [R19]
				if ((ctl_r[1:0] == OP_BYTE_PROGRAM || ctl_r[1:0] == OP_PAGE_ERASE) && in_area) begin
					state_nxt = ST_DONE;
				end else if (ctl_r[1:0] == OP_PAGE_ERASE && !size_ok) begin
					state_nxt = ST_DONE;
				end else begin
					req_nxt = 1'b1; // [R1]
				end
			end
			ST_RUN: begin
				if (cnt_r != 4'h0) begin
					cnt_nxt = cnt_r - 4'h1;
				end else if (FLASH_READY) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
				stall_nxt = 1'b0;
			end
		endcase
	end

	// reset entry: strobe window and vector selection
	always_comb begin
		win_nxt = win_r;
		service_nxt = service_r;
		vector_nxt = vector_r;
		if (win_r != 4'h0) begin
			win_nxt = win_r - 4'h1;
			// straps only count inside the window [R10] [R11] [R12]
			if ((STRAP_P2_EN && !sa_q && !sb_q) || (STRAP_P4_EN && !sc_q)) begin
				service_nxt = LOCK_N != 4'h0;
			end
			if (FLASH_BYTE0 == `BLANK_BYTE && LOCK_N != 4'h0) begin
				service_nxt = 1'b1; // [R8]
			end
		end
		vector_nxt = service_nxt ? area_start : 16'h0000;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			addr_high_r <= `SFR_RESET_VAL; // [R17]
			addr_low_r <= `SFR_RESET_VAL;
			wbyte_r <= `SFR_RESET_VAL;
			ctl_r <= `SFR_RESET_VAL;
			rdata_r <= 8'h00;
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			req_r <= 1'b0;
			stall_r <= 1'b0;
			win_r <= 4'(`STRAP_WINDOW_CYCLES);
			service_r <= 1'b0;
			vector_r <= 16'h0000;
			frd_r <= 8'h00;
		end else begin
			addr_high_r <= addr_high_nxt;
			addr_low_r <= addr_low_nxt;
			wbyte_r <= wbyte_nxt;
			ctl_r <= ctl_nxt;
			rdata_r <= rdata_nxt;
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			req_r <= req_nxt;
			stall_r <= stall_nxt;
			win_r <= win_nxt;
			service_r <= service_nxt;
			vector_r <= vector_nxt;
			frd_r <= FLASH_PROTECTED ? `PROTECTED_READ : FLASH_RDATA_RAW; // [R6] [R21]
		end
	end

	// flash command outputs
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			FLASH_ADDR <= 16'h0000;
			FLASH_LAST <= 16'h0000;
			FLASH_OP <= 2'h0;
			FLASH_WDATA <= 8'h00;
			FLASH_KEEP_FROM <= 16'h0000;
		end else if (state_r == ST_CHECK) begin
			FLASH_OP <= ctl_r[`CTL_OP_HI:`CTL_OP_LO]; // [R18]
			FLASH_ADDR <= (ctl_r[1:0] == OP_PAGE_ERASE) ? page_base : target; // [R20]
			FLASH_LAST <= (ctl_r[1:0] == OP_PAGE_ERASE) ? page_last : target;
			FLASH_WDATA <= wbyte_r;
			// chip erase stops short of the locked area [R5] [R7] [R21]
			FLASH_KEEP_FROM <= (LOCK_N == 4'h0) ? 16'hffff : area_start;
		end
	end

	assign SFR_RDATA = rdata_r;
	assign FLASH_REQ = req_r;
	assign FETCH_STALL = stall_r;
	assign FLASH_RDATA = frd_r;
	assign RESET_VECTOR = vector_r;
	assign SERVICE_MODE = service_r;
	// jump target for the core [R9]
	assign SERVICE_START = area_start;

	chk_stall_start: assert property (@(posedge CORE_CLK) disable iff (RESET)
		ctl_write && SFR_WDATA[7] && state_r == ST_IDLE |=> FETCH_STALL) // [R22]
		else $error("stall not raised");
	chk_area_no_req: assert property (@(posedge CORE_CLK) disable iff (RESET)
		state_r == ST_CHECK && in_area && ctl_r[1:0] != OP_CHIP_PROTECT && ctl_r[1:0] != OP_CHIP_ERASE
		|=> !FLASH_REQ) // [R15]
		else $error("service area request issued");
	chk_start_clear: assert property (@(posedge CORE_CLK) disable iff (RESET)
		state_r == ST_DONE |=> !ctl_r[7] && !FETCH_STALL) // [R22]
		else $error("start bit not cleared");
	chk_protect_read: assert property (@(posedge CORE_CLK) disable iff (RESET)
		FLASH_PROTECTED |=> FLASH_RDATA == 8'h00) // [R6]
		else $error("protected read leaked");
	chk_req_op: assert property (@(posedge CORE_CLK) disable iff (RESET)
		FLASH_REQ |-> FLASH_OP == ctl_r[1:0]) // [R18]
		else $error("op mismatch");
	chk_addr_form: assert property (@(posedge CORE_CLK) disable iff (RESET)
		FLASH_REQ && FLASH_OP == OP_BYTE_PROGRAM |-> FLASH_ADDR == {addr_high_r, addr_low_r}) // [R14]
		else $error("address not formed");
	chk_no_lock_entry: assert property (@(posedge CORE_CLK) disable iff (RESET)
		LOCK_N == 4'h0 && $stable(LOCK_N) && !service_r |=> !service_r) // [R3]
		else $error("service entry with no area");
	chk_page_align: assert property (@(posedge CORE_CLK) disable iff (RESET)
		FLASH_REQ && FLASH_OP == OP_PAGE_ERASE |-> FLASH_ADDR[6:0] == 7'h00) // [R20]
		else $error("page base misaligned");
	chk_window_only: assert property (@(posedge CORE_CLK) disable iff (RESET)
		win_r == 4'h0 |=> $stable(service_r)) // [R12]
		else $error("strap seen outside window");

	sequence seq_op_start;
		ctl_write && SFR_WDATA[`CTL_START_BIT] && state_r == ST_IDLE;
	endsequence
	sequence seq_op_issue;
		state_r == ST_CHECK ##1 FLASH_REQ && state_r == ST_RUN;
	endsequence
	sequence seq_op_refuse;
		state_r == ST_CHECK ##1 !FLASH_REQ && state_r == ST_DONE;
	endsequence
	chk_op_flow: assert property (@(posedge CORE_CLK) disable iff (RESET) // [R20]
		seq_op_start |=> seq_op_issue or seq_op_refuse)
		else $error("operation did not start");
	chk_req_pulse: assert property (@(posedge CORE_CLK) disable iff (RESET) // [R1]
		FLASH_REQ |=> !FLASH_REQ)
		else $error("request longer than one cycle");
	chk_busy_hold: assert property (@(posedge CORE_CLK) disable iff (RESET) // [R22]
		FLASH_REQ |-> FETCH_STALL [*8])
		else $error("stall dropped during operation");
	chk_prog_data: assert property (@(posedge CORE_CLK) disable iff (RESET) // [R16]
		FLASH_REQ && FLASH_OP == OP_BYTE_PROGRAM |-> FLASH_WDATA == wbyte_r)
		else $error("program data mismatch");
	chk_keep_area: assert property (@(posedge CORE_CLK) disable iff (RESET) // [R5]
		FLASH_REQ && FLASH_OP == OP_CHIP_ERASE && LOCK_N != 4'h0
		|-> FLASH_KEEP_FROM[8:0] == 9'h000 && FLASH_KEEP_FROM >= `REGION_BASE && FLASH_KEEP_FROM <= `REGION_TOP)
		else $error("erase bound outside region");
	chk_rdata_pass: assert property (@(posedge CORE_CLK) disable iff (RESET) // [R6]
		!FLASH_PROTECTED |=> FLASH_RDATA == $past(FLASH_RDATA_RAW))
		else $error("unprotected read altered");
	chk_sfr_read: assert property (@(posedge CORE_CLK) disable iff (RESET) // [R17]
		SFR_RD && SFR_ADDR == `SFR_OP_CONTROL |=> SFR_RDATA == $past(ctl_r))
		else $error("control read mismatch");
	chk_vector_area: assert property (@(posedge CORE_CLK) disable iff (RESET) // [R8]
		SERVICE_MODE |-> RESET_VECTOR[8:0] == 9'h000 && RESET_VECTOR >= `REGION_BASE)
		else $error("service vector outside region");
endmodule : flash_prog

/* rtl/flash_prog_defines.svh */
// offsets, field positions and timing counts for the in-system flash programmer
`ifndef FLASH_PROG_DEFINES_SVH
`define FLASH_PROG_DEFINES_SVH
`define SFR_ADDR_HIGH 8'hf4
`define SFR_ADDR_LOW 8'hf5
`define SFR_WRITE_BYTE 8'hf6
`define SFR_OP_CONTROL 8'hf7
`define SFR_RESET_VAL 8'h00
`define CTL_START_BIT 7
`define CTL_PGSE_BIT 6
`define CTL_PGS_HI 5
`define CTL_PGS_LO 4
`define CTL_OP_HI 1
`define CTL_OP_LO 0
`define CTL_WRITABLE_MASK 8'hf3
`define REGION_BASE 16'h4000
`define REGION_TOP 16'h4fff
`define LOCK_STEP_BYTES 16'h0200
`define LOCK_MAX 4'h8
`define BLANK_BYTE 8'hff
`define PROTECTED_READ 8'h00
`define OP_TIME_NS 40
`define OP_CYCLES ((`OP_TIME_NS + 3) / 4)
`define STRAP_WINDOW_CYCLES 8
`endif

/* rtl/flash_prog_pkg.sv */
// types for the in-system flash programmer
package flash_prog_pkg;
	typedef enum logic [1:0] {
		OP_BYTE_PROGRAM = 2'h0,
		OP_CHIP_PROTECT = 2'h1,
		OP_PAGE_ERASE = 2'h2,
		OP_CHIP_ERASE = 2'h3
	} flash_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CHECK = 2'h1,
		ST_RUN = 2'h3,
		ST_DONE = 2'h2
	} seq_state_t;
endpackage : flash_prog_pkg

/* rtl/strap_sync.sv */
// two-flop synchroniser for the entry strap pins
`timescale 1ns/100ps
module strap_sync (
	input wire logic clk,
	input wire logic d,
	output logic q
);
	logic meta_r;
	always_ff @(posedge clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule : strap_sync

/* rtl/service_area_map.sv */
// service area bounds and page base from lock value and page select
`timescale 1ns/100ps
`include "flash_prog_defines.svh"
module service_area_map (
	input wire logic clk,
	input wire logic [3:0] lock_n,
	input wire logic [15:0] target,
	input wire logic pgse,
	input wire logic [1:0] pgs,
	output logic [15:0] area_start,
	output logic in_area,
	output logic [15:0] page_base,
	output logic [15:0] page_last,
	output logic size_ok
);
	logic [3:0] n_clip;
	logic [15:0] start_c;
	logic [15:0] mask_c;
	always_comb begin
		n_clip = (lock_n > `LOCK_MAX) ? `LOCK_MAX : lock_n;
		// area grows down from the region top by one step per lock count [R2] [R4]
		start_c = 16'(`REGION_TOP + 16'h0001 - 16'(n_clip) * `LOCK_STEP_BYTES);
		mask_c = 16'h01ff;
		if (pgse && pgs == 2'h1) begin
			mask_c = 16'h00ff; // [R19]
		end else if (pgse && pgs == 2'h2) begin
			mask_c = 16'h007f; // [R19]
		end
	end
	// area bounds registered, they only move with the lock value or the address registers
	always_ff @(posedge clk) begin
		area_start <= start_c;
		// no area at lock zero [R3]
		in_area <= (n_clip != 4'h0) && (target >= start_c) && (target <= `REGION_TOP);
	end
	// page fields follow the control register at once, the check state reads them right after the write
	assign page_base = target & ~mask_c; // [R20]
	assign page_last = target | mask_c;
	assign size_ok = !(pgse && pgs == 2'h3); // [R19]
endmodule : service_area_map

/* sim/flash_array_model.sv */
// behavioural flash array answering the programmer's requests
`timescale 1ns/100ps
module flash_array_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic [1:0] op,
	input wire logic [15:0] first,
	input wire logic [15:0] last,
	input wire logic [7:0] wdata,
	input wire logic [15:0] keep_from,
	input wire logic [15:0] rd_addr,
	input wire logic [7:0] lat,
	output logic ready,
	output logic prot,
	output logic [7:0] rdata,
	output logic [7:0] byte0
);
	logic [7:0] mem [0:65535];
	logic [7:0] cnt_r;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		ready = 1'b1;
		prot = 1'b0;
		cnt_r = 8'h00;
	end
	assign rdata = mem[rd_addr];
	assign byte0 = mem[0];
	always @(posedge clk) begin
		if (rst) begin
			ready <= 1'b1;
			cnt_r <= 8'h00;
		end else if (req) begin
			ready <= 1'b0;
			cnt_r <= lat;
			case (op)
				2'h0: mem[first] <= mem[first] & wdata;
				2'h1: prot <= 1'b1;
				2'h2: for (int a = first; a <= last; a++) mem[a] <= 8'hff;
				default: for (int a = 0; a < keep_from; a++) mem[a] <= 8'hff;
			endcase
		end else if (cnt_r > 8'h01) begin
			cnt_r <= cnt_r - 8'h01;
		end else begin
			ready <= 1'b1;
		end
	end
endmodule : flash_array_model

/* sim/testbench.sv */
// self-checking bench for the in-system flash programmer
`timescale 1ns/100ps
`include "flash_prog_defines.svh"
module testbench
	import flash_prog_pkg::*;
;
	logic CORE_CLK = 1'b0, RESET = 1'b1, SFR_WR = 1'b0, SFR_RD = 1'b0, P2_EN = 1'b1, P4_EN = 1'b1;
	logic STRAP_A = 1'b1, STRAP_B = 1'b1, STRAP_C = 1'b1, PROT, READY, REQ, STALL, SMODE;
	logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, BYTE0, RAW, FRDATA, WDATA, lat = 8'h03;
	logic [3:0] LOCK_N = 4'h2;
	logic [1:0] OP;
	logic [15:0] FADDR, FLAST, KEEP, VEC, SSTART, rd_addr = 16'h0000;
	int n_mismatch = 0;
	int compares = 0;
	initial begin
		forever #2 CORE_CLK = ~CORE_CLK;
	end
	flash_prog i_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_ADDR(SFR_ADDR),
		.SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .LOCK_N(LOCK_N), .STRAP_P2_EN(P2_EN), .STRAP_P4_EN(P4_EN),
		.ENTRY_STRAP_A(STRAP_A), .ENTRY_STRAP_B(STRAP_B), .ENTRY_STRAP_C(STRAP_C), .FLASH_BYTE0(BYTE0),
		.FLASH_PROTECTED(PROT), .FLASH_READY(READY), .FLASH_RDATA_RAW(RAW), .FLASH_RDATA(FRDATA), .FLASH_REQ(REQ),
		.FLASH_OP(OP), .FLASH_ADDR(FADDR), .FLASH_LAST(FLAST), .FLASH_WDATA(WDATA), .FLASH_KEEP_FROM(KEEP),
		.FETCH_STALL(STALL), .RESET_VECTOR(VEC), .SERVICE_MODE(SMODE), .SERVICE_START(SSTART));
	flash_array_model i_flash (.clk(CORE_CLK), .rst(RESET), .req(REQ), .op(OP), .first(FADDR), .last(FLAST),
		.wdata(WDATA), .keep_from(KEEP), .rd_addr(rd_addr), .lat(lat), .ready(READY), .prot(PROT), .rdata(RAW),
		.byte0(BYTE0));
	task automatic conclude;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask : tick
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		SFR_WR = 1'b1;
		SFR_ADDR = a;
		SFR_WDATA = d;
		tick(1);
		SFR_WR = 1'b0;
	endtask : sfr_wr
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		tick(1);
		SFR_RD = 1'b1;
		SFR_ADDR = a;
		tick(1);
		SFR_RD = 1'b0;
		d = SFR_RDATA;
	endtask : sfr_rd
	// start an operation, check the request it raises and wait out the busy time
	task automatic run_op(input logic [7:0] ctl, input logic req, input logic [15:0] first, input logic [15:0] last);
		logic [7:0] d;
		int i;
		sfr_wr(`SFR_OP_CONTROL, ctl);
		chk("stall", 1'b1, STALL);
		tick(1);
		chk("req", req, REQ);
		if (req) chk("op", ctl[1:0], OP);
		if (req && !ctl[0]) chk("first", first, FADDR);
		if (req && !ctl[0]) chk("last", last, FLAST);
		for (i = 0; i < 300 && STALL !== 1'b0; i++) tick(1);
		if (i == 300) begin
			n_mismatch++;
			conclude();
		end
		sfr_rd(`SFR_OP_CONTROL, d);
		chk("ctl", ctl & 8'h73, d);
	endtask : run_op
	task automatic op_at(input logic [15:0] a, input logic [7:0] d, input logic [7:0] ctl, input logic req);
		sfr_wr(`SFR_ADDR_HIGH, a[15:8]);
		sfr_wr(`SFR_ADDR_LOW, a[7:0]);
		sfr_wr(`SFR_WRITE_BYTE, d);
		run_op(ctl, req, a, a);
	endtask : op_at
	task automatic t_regs;
		logic [7:0] d;
		logic [7:0] v [4] = '{8'ha5, 8'h5a, 8'h3c, 8'h7f};
		for (int i = 0; i < 5; i++) begin
			sfr_rd(8'hf0 + i[7:0] * 8'h01 + 8'h04 - (i == 4 ? 8'h14 : 8'h00), d);
			chk("reset value", 8'h00, d);
		end
		for (int i = 0; i < 4; i++) sfr_wr(8'hf4 + i[7:0], v[i]);
		for (int i = 0; i < 4; i++) begin
			sfr_rd(8'hf4 + i[7:0], d);
			chk("readback", i == 3 ? 8'h73 : v[i], d);
		end
		$display("test regs done");
	endtask : t_regs
	task automatic t_program;
		op_at(16'h1005, 8'h22, 8'h80, 1'b1);
		chk("wdata", 8'h22, WDATA);
		rd_addr = 16'h1005;
		tick(2);
		chk("read", 8'h22, FRDATA);
		lat = 8'h1e;
		op_at(16'h0000, 8'h00, 8'h80, 1'b1);
		op_at(16'h4c10, 8'h11, 8'h80, 1'b0);
		op_at(16'h4c00, 8'h11, 8'h82, 1'b0);
		op_at(16'h4bff, 8'h11, 8'h80, 1'b1);
		LOCK_N = 4'h0;
		op_at(16'h4c10, 8'h11, 8'h80, 1'b1);
		LOCK_N = 4'h2;
		lat = 8'h03;
		$display("test program done");
	endtask : t_program
	task automatic t_reset;
		logic [5:0] tb [6] = '{6'b110011, 6'b110001, 6'b110101, 6'b111101, 6'b010010, 6'b101100};
		foreach (tb[i]) begin
			{P2_EN, P4_EN, STRAP_A, STRAP_B, STRAP_C} = tb[i][5:1];
			RESET = 1'b1;
			tick(20);
			RESET = 1'b0;
			tick(14);
			{STRAP_A, STRAP_B, STRAP_C} = 3'b111;
			tick(2);
			chk("entry", tb[i][0], SMODE);
			chk("vector", tb[i][0] ? 16'h4c00 : 16'h0000, VEC);
		end
		{STRAP_A, STRAP_B} = 2'b00;
		tick(10);
		chk("late strap", 1'b0, SMODE);
		{P2_EN, P4_EN, STRAP_A, STRAP_B} = 4'hf;
		$display("test reset done");
	endtask : t_reset
	task automatic t_page;
		logic [7:0] c [5] = '{8'h82, 8'hc2, 8'hd2, 8'he2, 8'hf2};
		logic [15:0] m [5] = '{16'hfe00, 16'hfe00, 16'hff00, 16'hff80, 16'hff80};
		foreach (c[i]) begin
			sfr_wr(`SFR_ADDR_HIGH, 8'h12);
			sfr_wr(`SFR_ADDR_LOW, 8'hb4);
			run_op(c[i], i != 4, 16'h12b4 & m[i], (16'h12b4 & m[i]) | ~m[i]);
		end
		$display("test page done");
	endtask : t_page
	task automatic t_chip;
		logic [15:0] start;
		for (int n = 0; n < 9; n++) begin
			LOCK_N = n[3:0];
			start = 16'h5000 - n[15:0] * `LOCK_STEP_BYTES;
			tick(1);
			if (n > 0) chk("service start", start, SSTART);
			run_op(8'h83, 1'b1, 16'h0000, 16'h0000);
			chk("keep from", n == 0 ? 16'hffff : start, KEEP);
		end
		$display("test chip done");
	endtask : t_chip
	task automatic t_blank;
		tick(14);
		chk("blank vector", 16'h4c00, VEC);
		chk("blank entry", 1'b1, SMODE);
		$display("test blank done");
	endtask : t_blank
	task automatic t_protect;
		run_op(8'h81, 1'b1, 16'h0000, 16'h0000);
		rd_addr = 16'h4f00;
		tick(3);
		chk("protected read", `PROTECTED_READ, FRDATA);
		$display("test protect done");
	endtask : t_protect
	initial begin
		tick(20);
		RESET = 1'b0;
		t_blank();
		t_regs();
		t_program();
		t_reset();
		t_page();
		t_chip();
		t_protect();
		conclude();
	end
endmodule : testbench
